// file: include/lfs_pkg.sv
/*
 * constants, register map and state type of the lamp fault supervisor.
 * assumes one 40 MHz system clock and a synchronous active-low reset.
 */
// Operation
// - overcurrent at maximum frequency stops at once
// - overvoltage starts timer, discharges loop cap next cycle
// - extra overvoltage past activation delay stops
// - hard switching in ignition/burn starts timer
// - overtemp with low gate high: standby until release
// - timer faults qualified by activation delay first
// - timer runs eight charges and seven discharges
// - timeout goes to stop or auto-restart
// - fault gone past release delay resets timer
// - shorted timing cap holds maximum frequency
// - fault and preheat timers share timing cap
// - pfc clamp and low feedback enable brownout help
// - brownout feedback level starts fault timer
package lfs_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int FAULT_ACT_NS = 1000;
    localparam int FAULT_REL_NS = 2000;
    localparam int RESTART_NS = 10000;
    localparam int FAULT_ACT_CYC = (FAULT_ACT_NS * CLK_MHZ + 999) / 1000;
    localparam int FAULT_REL_CYC = (FAULT_REL_NS * CLK_MHZ + 999) / 1000;
    localparam int RESTART_CYC = (RESTART_NS * CLK_MHZ + 999) / 1000;
    localparam int QUAL_CW = 8;
    localparam int RESTART_CW = 12;

    // ----------------------------------------------------------------
    // fault timer
    // ----------------------------------------------------------------
    localparam logic [3:0] LAST_PHASE = 4'hE;
    localparam logic [1:0] MAX_IGN_TRIES = 2'h2;

    // ----------------------------------------------------------------
    // comparator vector positions
    // ----------------------------------------------------------------
    localparam int NCMP = 12;
    localparam int C_OC = 0;
    localparam int C_OV = 1;
    localparam int C_OVX = 2;
    localparam int C_HS = 3;
    localparam int C_OT_TRIP = 4;
    localparam int C_OT_REL = 5;
    localparam int C_CAP_HI = 6;
    localparam int C_CAP_LO = 7;
    localparam int C_CAP_SHORT = 8;
    localparam int C_PFC_CLAMP = 9;
    localparam int C_PFC_LOW = 10;
    localparam int C_PFC_BO = 11;

    // qualified faults: 0..2 timed, 3 extra overvoltage
    localparam int NQ = 4;
    localparam int Q_OV = 0;
    localparam int Q_HS = 1;
    localparam int Q_BO = 2;
    localparam int Q_OVX = 3;

    // ----------------------------------------------------------------
    // lamp phase codes
    // ----------------------------------------------------------------
    localparam logic [1:0] PHASE_PREHEAT = 2'h0;
    localparam logic [1:0] PHASE_IGN = 2'h1;
    localparam logic [1:0] PHASE_BURN = 2'h2;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CMD = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_IGN = 4'hC;
    localparam int CTRL_RESTART_EN = 0;
    localparam int CMD_CLEAR = 0;
    localparam logic CTRL_RESET = 1'h1;

    typedef enum logic [1:0] {
        SUP_RUN,
        SUP_STANDBY,
        SUP_STOP,
        SUP_RESTART
    } lfs_sup_t;

endpackage

// file: core/lfs_qual.sv
/*
 * activation/release delay filter for one synchronised fault level.
 * assumes its input is already on the system clock.
 */
`timescale 1ns/1ps
module lfs_qual #(
    parameter int ACT_CYC = 40,
    parameter int REL_CYC = 80,
    parameter int CW = 8
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // fault level
    input wire logic fault_in,
    output logic qual_out
);
    import lfs_pkg::*;

    logic [CW-1:0] cnt;

    // ----------------------------------------------------------------
    // delay filter
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            qual_out <= 1'b0;
            cnt <= '0;
        end else if (fault_in == qual_out) begin
            cnt <= '0;
        end else if (fault_in && cnt >= CW'(ACT_CYC - 1)) begin
            qual_out <= 1'b1;
            cnt <= '0;
        end else if (!fault_in && cnt >= CW'(REL_CYC - 1)) begin
            qual_out <= 1'b0;
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    property p_qual_rise;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        $rose(qual_out) |-> $past(fault_in);
    endproperty
    a_qual_rise: assert property (p_qual_rise)
        else $error("qualified fault rose without fault");

endmodule

// file: core/lfs_supervisor.sv
/*
 * lamp fault supervisor: comparator sync, stop/standby decisions,
 * fault timer on the shared timing cap, wishbone register slave.
 * assumes comparators are asynchronous levels and that phase,
 * gate and cycle-start inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module lfs_supervisor #(
    parameter int ACT_CYC = lfs_pkg::FAULT_ACT_CYC,
    parameter int REL_CYC = lfs_pkg::FAULT_REL_CYC,
    parameter int RESTART_CYC = lfs_pkg::RESTART_CYC
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // comparators (asynchronous)
    input wire logic lamp_current_sense_oc_in,
    input wire logic lamp_voltage_sense_ov_in,
    input wire logic lamp_voltage_sense_ovx_in,
    input wire logic hard_switch_in,
    input wire logic overtemp_trip_level_in,
    input wire logic overtemp_release_level_in,
    input wire logic timing_cap_pin_high_in,
    input wire logic timing_cap_pin_low_in,
    input wire logic timing_cap_pin_short_in,
    input wire logic pfc_error_amp_out_clamp_in,
    input wire logic pfc_feedback_low_in,
    input wire logic pfc_feedback_bo_in,
    // same-clock controller signals
    input wire logic [1:0] lamp_phase_in,
    input wire logic max_switch_freq_in,
    input wire logic low_side_gate_in,
    input wire logic cycle_start_in,
    input wire logic preheat_charge_in,
    // analog requests and state
    output logic timing_cap_charge_out,
    output logic timed_fault_out,
    output logic current_loop_cap_dch_out,
    output logic max_switch_freq_hold_out,
    output logic brownout_comp_out,
    output logic stop_out,
    output logic standby_out,
    output logic auto_restart_out
);
    import lfs_pkg::*;

    logic [NCMP-1:0] cmp_m;
    logic [NCMP-1:0] cmp_s;
    logic cap_hi_d;
    logic cap_lo_d;
    logic [NQ-1:0] q_raw;
    logic [NQ-1:0] qual;
    logic timer_run;
    logic [1:0] timer_src;
    logic [3:0] phase_cnt;
    logic charging;
    logic timeout;
    logic cap_hi_rise;
    logic cap_lo_rise;
    logic ov_pending;
    logic hard_stop;
    logic ovx_d;
    lfs_sup_t state;
    lfs_sup_t next_state;
    logic [RESTART_CW-1:0] restart_cnt;
    logic [1:0] ign_tries;
    logic [1:0] phase_d;
    logic restart_en;
    logic clear_cmd;
    logic wb_hit;

    function automatic logic [1:0] first_set(input logic [2:0] v);
        first_set = v[0] ? 2'h0 : (v[1] ? 2'h1 : 2'h2);
    endfunction

    // ----------------------------------------------------------------
    // comparator synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            cmp_m <= '0;
            cmp_s <= '0;
        end else begin
            cmp_m <= {pfc_feedback_bo_in, pfc_feedback_low_in,
                      pfc_error_amp_out_clamp_in, timing_cap_pin_short_in,
                      timing_cap_pin_low_in, timing_cap_pin_high_in,
                      overtemp_release_level_in, overtemp_trip_level_in,
                      hard_switch_in, lamp_voltage_sense_ovx_in,
                      lamp_voltage_sense_ov_in,
                      lamp_current_sense_oc_in};
            cmp_s <= cmp_m;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            cap_hi_d <= 1'b0;
            cap_lo_d <= 1'b0;
        end else begin
            cap_hi_d <= cmp_s[C_CAP_HI];
            cap_lo_d <= cmp_s[C_CAP_LO];
        end
    end

    assign cap_hi_rise = cmp_s[C_CAP_HI] && !cap_hi_d;
    assign cap_lo_rise = cmp_s[C_CAP_LO] && !cap_lo_d;

    // ----------------------------------------------------------------
    // fault qualification
    // ----------------------------------------------------------------
    assign q_raw[Q_OV] = cmp_s[C_OV];
    assign q_raw[Q_HS] = cmp_s[C_HS] && (lamp_phase_in == PHASE_IGN ||
                         lamp_phase_in == PHASE_BURN);
    assign q_raw[Q_BO] = cmp_s[C_PFC_BO];
    assign q_raw[Q_OVX] = cmp_s[C_OVX];

    genvar gi;
    generate
        for (gi = 0; gi < NQ; gi++) begin : g_qual
            lfs_qual #(
                .ACT_CYC(ACT_CYC),
                .REL_CYC(REL_CYC),
                .CW(QUAL_CW)
            ) u_qual (
                .ref_clk_in(ref_clk_in),
                .reset_n_in(reset_n_in),
                .fault_in(q_raw[gi]),
                .qual_out(qual[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // fault timer
    // ----------------------------------------------------------------
    assign timeout = timer_run && charging && cap_hi_rise &&
                     phase_cnt == LAST_PHASE;

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            timer_run <= 1'b0;
            timer_src <= 2'h0;
        end else if (state != SUP_RUN || timeout) begin
            timer_run <= 1'b0;
        end else if (!timer_run && |qual[Q_BO:Q_OV]) begin
            timer_run <= 1'b1;
            timer_src <= first_set(qual[Q_BO:Q_OV]);
        end else if (timer_run && !qual[timer_src]) begin
            timer_run <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            phase_cnt <= 4'h0;
            charging <= 1'b1;
        end else if (!timer_run || timeout) begin
            phase_cnt <= 4'h0;
            charging <= 1'b1;
        end else if (charging && cap_hi_rise) begin
            phase_cnt <= phase_cnt + 4'h1;
            charging <= 1'b0;
        end else if (!charging && cap_lo_rise) begin
            phase_cnt <= phase_cnt + 4'h1;
            charging <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            timing_cap_charge_out <= 1'b0;
            timed_fault_out <= 1'b0;
        end else begin
            timing_cap_charge_out <= timer_run ? charging
                                     : preheat_charge_in;
            timed_fault_out <= timer_run;
        end
    end

    // ----------------------------------------------------------------
    // frequency and power requests
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ov_pending <= 1'b0;
            current_loop_cap_dch_out <= 1'b0;
        end else begin
            if (cycle_start_in) begin
                current_loop_cap_dch_out <= ov_pending;
                ov_pending <= cmp_s[C_OV];
            end else if (cmp_s[C_OV]) begin
                ov_pending <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            max_switch_freq_hold_out <= 1'b0;
            brownout_comp_out <= 1'b0;
        end else begin
            max_switch_freq_hold_out <= cmp_s[C_CAP_SHORT];
            brownout_comp_out <= cmp_s[C_PFC_CLAMP] &&
                                 cmp_s[C_PFC_LOW];
        end
    end

    // ----------------------------------------------------------------
    // ignition attempts
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            phase_d <= PHASE_PREHEAT;
            ign_tries <= 2'h0;
        end else begin
            phase_d <= lamp_phase_in;
            if (clear_cmd) begin
                ign_tries <= 2'h0;
            end else if (lamp_phase_in == PHASE_IGN &&
                         phase_d != PHASE_IGN && ign_tries != 2'h3) begin
                ign_tries <= ign_tries + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // supervisor state
    // ----------------------------------------------------------------
    // previous qualified extra overvoltage, for its rising edge
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ovx_d <= 1'b0;
        end else begin
            ovx_d <= qual[Q_OVX];
        end
    end

    assign hard_stop = (cmp_s[C_OC] && max_switch_freq_in)
                       || (qual[Q_OVX] && !ovx_d);

    always_comb begin
        next_state = state;
        case (state)
            SUP_RUN: begin
                if (hard_stop) begin
                    next_state = SUP_STOP;
                end else if (timeout) begin
                    if (timer_src != 2'(Q_BO) && restart_en &&
                        lamp_phase_in == PHASE_IGN &&
                        ign_tries < MAX_IGN_TRIES) begin
                        next_state = SUP_RESTART;
                    end else begin
                        next_state = SUP_STOP;
                    end
                end else if (cmp_s[C_OT_TRIP] && low_side_gate_in) begin
                    next_state = SUP_STANDBY;
                end
            end
            SUP_STANDBY: begin
                if (cmp_s[C_OT_REL]) begin
                    next_state = SUP_RUN;
                end
            end
            SUP_STOP: begin
                if (clear_cmd) begin
                    next_state = SUP_RUN;
                end
            end
            SUP_RESTART: begin
                if (restart_cnt == RESTART_CW'(RESTART_CYC - 1)) begin
                    next_state = SUP_RUN;
                end
            end
            default: begin
                next_state = SUP_STOP;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            state <= SUP_RUN;
            restart_cnt <= '0;
        end else begin
            state <= next_state;
            if (state == SUP_RESTART) begin
                restart_cnt <= restart_cnt + 1'b1;
            end else begin
                restart_cnt <= '0;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            stop_out <= 1'b0;
            standby_out <= 1'b0;
            auto_restart_out <= 1'b0;
        end else begin
            stop_out <= next_state == SUP_STOP;
            standby_out <= next_state == SUP_STANDBY;
            auto_restart_out <= next_state == SUP_RESTART;
        end
    end

    // ----------------------------------------------------------------
    // wishbone registers
    // ----------------------------------------------------------------
    assign wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign clear_cmd = wb_hit && wb_we_in && wb_adr_in == REG_CMD &&
                       wb_sel_in[0] && wb_dat_in[CMD_CLEAR];

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            wb_ack_out <= 1'b0;
            restart_en <= CTRL_RESET;
        end else begin
            wb_ack_out <= wb_hit;
            if (wb_hit && wb_we_in && wb_adr_in == REG_CTRL &&
                wb_sel_in[0]) begin
                restart_en <= wb_dat_in[CTRL_RESTART_EN];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            wb_dat_out <= 32'h0;
        end else if (wb_hit && !wb_we_in) begin
            case (wb_adr_in)
                REG_CTRL: wb_dat_out <= {31'h0, restart_en};
                REG_STATUS: wb_dat_out <= {19'h0, cmp_s[C_CAP_SHORT],
                    qual, phase_cnt, timer_run, charging, state};
                REG_IGN: wb_dat_out <= {30'h0, ign_tries};
                default: wb_dat_out <= 32'h0;
            endcase
        end else begin
            wb_dat_out <= 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_oc_stop;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state == SUP_RUN && cmp_s[C_OC] && max_switch_freq_in)
            |=> (state == SUP_STOP && stop_out);
    endproperty
    a_oc_stop: assert property (p_oc_stop)
        else $error("overcurrent at max frequency did not stop");

    property p_ov_dch;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (cycle_start_in && ov_pending) |=> current_loop_cap_dch_out;
    endproperty
    a_ov_dch: assert property (p_ov_dch)
        else $error("overvoltage discharge not requested");

    property p_ovx_stop;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state == SUP_RUN && $rose(qual[Q_OVX])) |=> state == SUP_STOP;
    endproperty
    a_ovx_stop: assert property (p_ovx_stop)
        else $error("extra overvoltage did not stop");

    property p_hs_gate;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (lamp_phase_in == PHASE_PREHEAT) |-> !q_raw[Q_HS];
    endproperty
    a_hs_gate: assert property (p_hs_gate)
        else $error("hard switching counted outside ignition/burn");

    property p_standby_hold;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state == SUP_STANDBY && !cmp_s[C_OT_REL])
            |=> (state == SUP_STANDBY && standby_out);
    endproperty
    a_standby_hold: assert property (p_standby_hold)
        else $error("standby left before temperature release");

    property p_timer_start;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        $rose(timer_run) |-> $past(qual[Q_OV] | qual[Q_HS] | qual[Q_BO]);
    endproperty
    a_timer_start: assert property (p_timer_start)
        else $error("fault timer started without qualified fault");

    property p_timeout_exit;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state == SUP_RUN && timeout)
            |=> (state == SUP_STOP || state == SUP_RESTART) && !timer_run;
    endproperty
    a_timeout_exit: assert property (p_timeout_exit)
        else $error("fault timeout did not leave run");

    property p_phase_clear;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        !timer_run |=> phase_cnt == 4'h0 && charging;
    endproperty
    a_phase_clear: assert property (p_phase_clear)
        else $error("phase count not cleared while idle");

    property p_short_hold;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        cmp_s[C_CAP_SHORT] |=> max_switch_freq_hold_out;
    endproperty
    a_short_hold: assert property (p_short_hold)
        else $error("shorted timing cap did not hold max frequency");

    property p_brownout;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (cmp_s[C_PFC_CLAMP] && cmp_s[C_PFC_LOW]) |=> brownout_comp_out;
    endproperty
    a_brownout: assert property (p_brownout)
        else $error("brownout compensation not enabled");

endmodule

// file: verification/lfs_cap_model.sv
/*
 * timing cap model: ramps up while charged, down while discharged.
 * assumes charge request is a same-clock level from the supervisor.
 */
`timescale 1ns/1ps
module lfs_cap_model (
    // clock
    input wire logic ref_clk_in,
    // drive and comparators
    input wire logic charge_in,
    output logic high_out,
    output logic low_out
);
    logic [3:0] volt = 4'h0;
    // one ramp serves fault and preheat timers alike
    always_ff @(posedge ref_clk_in) begin
        if (charge_in && volt != 4'hF) begin
            volt <= volt + 4'h1;
        end else if (!charge_in && volt != 4'h0) begin
            volt <= volt - 4'h1;
        end
    end
    assign high_out = volt > 4'hC;
    assign low_out = volt < 4'h3;
endmodule

// file: verification/tb_lfs_supervisor.sv
/*
 * self-checking bench of the supervisor with a timing cap model.
 * assumes lfs_pkg and lfs_cap_model are compiled first.
 */
`timescale 1ns/1ps
module tb_lfs_supervisor;
    import lfs_pkg::*;
    localparam int ACT = 4;
    localparam int REL = 6;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0, rd, q, rnd = 32'hF34CA8AC;
    logic oc = 1'b0, ov = 1'b0, ovx = 1'b0, hs = 1'b0, trip = 1'b0;
    logic rel = 1'b0, sc = 1'b0, clamp = 1'b0, low = 1'b0, bo = 1'b0;
    logic maxf = 1'b0, gate = 1'b0, cs = 1'b0, phc = 1'b0;
    logic [1:0] ph = 2'h0;
    logic ack, ch, cl, chg, tf, dch, hold, boc, stp, sby, ar;
    int err_total = 0, checked = 0, f;
    lfs_supervisor #(.ACT_CYC(ACT), .REL_CYC(REL), .RESTART_CYC(10))
    u_lfs_supervisor (.ref_clk_in(clk), .reset_n_in(rst_n),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat),
        .wb_dat_out(rd), .wb_ack_out(ack),
        .lamp_current_sense_oc_in(oc), .lamp_voltage_sense_ov_in(ov),
        .lamp_voltage_sense_ovx_in(ovx), .hard_switch_in(hs),
        .overtemp_trip_level_in(trip), .overtemp_release_level_in(rel),
        .timing_cap_pin_high_in(ch), .timing_cap_pin_low_in(cl),
        .timing_cap_pin_short_in(sc), .pfc_error_amp_out_clamp_in(clamp),
        .pfc_feedback_low_in(low), .pfc_feedback_bo_in(bo),
        .lamp_phase_in(ph), .max_switch_freq_in(maxf),
        .low_side_gate_in(gate), .cycle_start_in(cs),
        .preheat_charge_in(phc), .timing_cap_charge_out(chg),
        .timed_fault_out(tf), .current_loop_cap_dch_out(dch),
        .max_switch_freq_hold_out(hold), .brownout_comp_out(boc),
        .stop_out(stp), .standby_out(sby), .auto_restart_out(ar));
    lfs_cap_model u_lfs_cap_model (.ref_clk_in(clk), .charge_in(chg),
        .high_out(ch), .low_out(cl));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        rnd <= lfsr(rnd);
        cs <= rnd[0] & ~cs;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) chk("ack", 32'h1, 32'h0);
        @(posedge clk);
    endtask
    task automatic run_timer();
        int n;
        logic p;
        n = 0;
        f = 0;
        p = 1'b0;
        while (ar !== 1'b1 && stp !== 1'b1 && n < 1000) begin
            @(posedge clk);
            if (p === 1'b1 && chg === 1'b0 && tf === 1'b1) f++;
            p = chg;
            n++;
        end
    endtask
    task automatic final_report();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #1000000;
        err_total++;
        final_report();
    end
    initial begin
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h1, q);
        wb(1'b1, REG_CTRL, rnd | 32'h1);
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", 32'h1, q);
        wb(1'b1, 4'h6, rnd);
        wb(1'b0, 4'h6, 32'h0);
        chk("unmapped", 32'h0, q);
        phc <= 1'b1;
        tick(3);
        chk("preheat charge", 1, chg);
        phc <= 1'b0;
        oc <= 1'b1;
        tick(6);
        chk("stop no maxfreq", 0, stp);
        maxf <= 1'b1;
        tick(5);
        chk("stop oc", 1, stp);
        oc <= 1'b0;
        maxf <= 1'b0;
        wb(1'b1, REG_CMD, 32'h1);
        tick(2);
        chk("stop clear", 0, stp);
        sc <= 1'b1;
        tick(5);
        chk("max freq hold", 1, hold);
        sc <= 1'b0;
        clamp <= 1'b1;
        low <= 1'b1;
        tick(5);
        chk("brownout help", 1, boc);
        clamp <= 1'b0;
        tick(5);
        chk("brownout off", 0, boc);
        low <= 1'b0;
        gate <= 1'b1;
        trip <= 1'b1;
        tick(5);
        chk("standby", 1, sby);
        trip <= 1'b0;
        tick(5);
        chk("standby held", 1, sby);
        rel <= 1'b1;
        tick(5);
        chk("standby left", 0, sby);
        rel <= 1'b0;
        gate <= 1'b0;
        ov <= 1'b1;
        tick(ACT - 1);
        ov <= 1'b0;
        tick(8);
        chk("short ov", 0, tf);
        ov <= 1'b1;
        tick(ACT + 30);
        chk("ov timer", 1, tf);
        chk("ov discharge", 1, dch);
        ov <= 1'b0;
        tick(REL + 8);
        chk("timer reset", 0, tf);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("status idle", 32'h4, q);
        ph <= PHASE_IGN;
        hs <= 1'b1;
        run_timer();
        chk("charge ends", 7, f);
        chk("restart", 1, ar);
        hs <= 1'b0;
        tick(20);
        chk("restart over", 0, ar | stp);
        wb(1'b0, REG_IGN, 32'h0);
        chk("ign tries", 32'h1, q);
        ph <= PHASE_BURN;
        bo <= 1'b1;
        run_timer();
        chk("bo stop", 1, stp);
        bo <= 1'b0;
        wb(1'b1, REG_CMD, 32'h1);
        ovx <= 1'b1;
        tick(ACT + 6);
        chk("ovx stop", 1, stp);
        final_report();
    end
endmodule
